// ==== hw/pfp_axil_slave.sv ====
// axi4-lite slave that turns bus transfers into register accesses
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
module pfp_axil_slave (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address and data
    input wire logic [`PFP_ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // read address and data
    input wire logic [`PFP_ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // register side
    pfp_reg_if.slave rif
);
    logic aw_h_r, w_h_r, ar_h_r;
    logic [`PFP_ADDR_W-1:0] awaddr_r, araddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_take, w_take, ar_take, wr_go, rd_go;
    logic aw_h_nxt, w_h_nxt, ar_h_nxt, bvalid_nxt, rvalid_nxt;

    // handshakes and the one-cycle register strobes
    assign aw_take = s_awvalid & s_awready;
    assign w_take = s_wvalid & s_wready;
    assign ar_take = s_arvalid & s_arready;
    assign wr_go = aw_h_r & w_h_r & ~s_bvalid;
    assign rd_go = ar_h_r & ~s_rvalid;
    assign aw_h_nxt = (aw_h_r | aw_take) & ~wr_go;
    assign w_h_nxt = (w_h_r | w_take) & ~wr_go;
    assign ar_h_nxt = (ar_h_r | ar_take) & ~rd_go;
    assign bvalid_nxt = wr_go | (s_bvalid & ~s_bready);
    assign rvalid_nxt = rd_go | (s_rvalid & ~s_rready);
    assign rif.wr_en = wr_go;
    assign rif.wr_addr = awaddr_r;
    assign rif.wr_data = wdata_r;
    assign rif.wr_strb = wstrb_r;
    assign rif.rd_addr = araddr_r;

    // write channels: address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_h_r <= 1'b0;
            w_h_r <= 1'b0;
            s_awready <= 1'b0;
            s_wready <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `PFP_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            aw_h_r <= aw_h_nxt;
            w_h_r <= w_h_nxt;
            s_awready <= ~aw_h_nxt & ~bvalid_nxt; // one write under way at a time
            s_wready <= ~w_h_nxt & ~bvalid_nxt;
            s_bvalid <= bvalid_nxt;
            if (aw_take) begin
                awaddr_r <= s_awaddr;
            end
            if (w_take) begin
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            if (wr_go) begin
                s_bresp <= rif.wr_hit ? `PFP_RESP_OKAY : `PFP_RESP_SLVERR;
            end
        end
    end

    // read channel: data sampled the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_h_r <= 1'b0;
            s_arready <= 1'b0;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= `PFP_RESP_OKAY;
            araddr_r <= '0;
        end else begin
            ar_h_r <= ar_h_nxt;
            s_arready <= ~ar_h_nxt & ~rvalid_nxt;
            s_rvalid <= rvalid_nxt;
            if (ar_take) begin
                araddr_r <= s_araddr;
            end
            if (rd_go) begin
                s_rdata <= rif.rd_data;
                s_rresp <= rif.rd_hit ? `PFP_RESP_OKAY : `PFP_RESP_SLVERR;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hw/pfp_cfg.svh ====
// constants of the program flash protection controller: offsets, fields, reset values
`ifndef PFP_CFG_SVH
`define PFP_CFG_SVH

// ==========================================================
// register map (byte addresses, one aligned word each)
`define PFP_ADDR_W 8
`define PFP_OFF_STATUS 8'h04
`define PFP_OFF_PROT 8'h08

// ==========================================================
// protection register fields
`define PFP_BIT_OPEN 7
`define PFP_BIT_RNV 6
`define PFP_BIT_HDIS 5
`define PFP_HS_HI 4
`define PFP_HS_LO 3
`define PFP_BIT_LDIS 2
`define PFP_LS_HI 1
`define PFP_LS_LO 0
`define PFP_RNV_MASK 8'h40
`define PFP_PROT_RESET 8'h7f
`define PFP_PROT_FAULT 8'h7f

// ==========================================================
// status register fields
`define PFP_BIT_VIOL 4
`define PFP_BIT_LOADED 0

// ==========================================================
// address map of the array
`define PFP_GADDR_W 24
`define PFP_NV_ADDR 24'hfffe0c
`define PFP_ARRAY_BASE 24'hff8000
`define PFP_HI_START_MIN 24'hfff800
`define PFP_LO_SIZE_MIN 24'h000400

// ==========================================================
// scenario transitions, row = from scenario, bit = to scenario
`define PFP_TRANS_TABLE {8'hff, 8'h5a, 8'h3c, 8'h18, 8'h08, 8'h0c, 8'h0a, 8'h0f}

// ==========================================================
// bus responses
`define PFP_RESP_OKAY 2'h0
`define PFP_RESP_SLVERR 2'h2

`endif

// ==== hw/pfp_ctrl.sv ====
// program flash protection controller: register, reset load and command screening
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
module pfp_ctrl (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite register port
    input wire logic [`PFP_ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [`PFP_ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // operating mode pin, high in special single chip mode
    input wire logic special_mode,
    // reset-time read of the nonvolatile protection byte
    output logic nv_read_req,
    output logic [`PFP_GADDR_W-1:0] nv_read_addr,
    input wire logic nv_valid,
    input wire logic [7:0] nv_data,
    input wire logic nv_dbl_fault,
    // command screening from the memory controller
    input wire logic cmd_valid,
    input wire pfp_pkg::pfp_cmd_e cmd_kind,
    input wire logic [`PFP_GADDR_W-1:0] cmd_addr,
    output logic cmd_accept,
    output logic cmd_refuse,
    // state seen by the rest of the flash module
    output logic [7:0] prot_value,
    output logic protection_violation_flag
);
    import pfp_pkg::*;

    // ==========================================================
    // bus slave
    pfp_reg_if rif ();

    pfp_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .rif(rif)
    );

    // ==========================================================
    // mode pin synchroniser
    logic mode_meta_r, mode_r;

    // the pin is asynchronous to aclk, so two flops before any use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_meta_r <= 1'b0;
            mode_r <= 1'b0;
        end else begin
            mode_meta_r <= special_mode;
            mode_r <= mode_meta_r;
        end
    end

    // ==========================================================
    // state
    pfp_load_e load_r, load_nxt;
    logic [7:0] prot_r, prot_nxt;
    logic viol_r, viol_nxt;
    logic accept_r, refuse_r;
    logic [`PFP_GADDR_W-1:0] nv_addr_r;
    logic nv_req_r;

    // ==========================================================
    // register decode
    logic wr_prot, wr_status, prot_lane, rd_prot, rd_status;

    assign prot_lane = rif.wr_strb[0];
    assign wr_prot = rif.wr_en & (rif.wr_addr == `PFP_OFF_PROT) & prot_lane;
    assign wr_status = rif.wr_en & (rif.wr_addr == `PFP_OFF_STATUS) & prot_lane;
    assign rif.wr_hit = (rif.wr_addr == `PFP_OFF_PROT) | (rif.wr_addr == `PFP_OFF_STATUS);
    assign rd_prot = rif.rd_addr == `PFP_OFF_PROT;
    assign rd_status = rif.rd_addr == `PFP_OFF_STATUS;
    assign rif.rd_hit = rd_prot | rd_status;

    // read mux: narrow registers in the low byte, upper bits zero
    assign rif.rd_data = rd_prot ? {24'h000000, prot_r} :
        rd_status ? {27'h0, viol_r, 3'h0, load_r == PFP_LOAD_DONE} : 32'h00000000;

    // ==========================================================
    // protection write filter
    logic [7:0] wbyte, w_norm, w_spec;
    pfp_scen_t scen_cur, scen_new;
    logic [63:0] trans_tbl;
    logic trans_ok;

    assign wbyte = rif.wr_data[7:0];
    assign scen_cur = {prot_r[`PFP_BIT_OPEN], prot_r[`PFP_BIT_HDIS], prot_r[`PFP_BIT_LDIS]};
    assign scen_new = {wbyte[`PFP_BIT_OPEN], wbyte[`PFP_BIT_HDIS], wbyte[`PFP_BIT_LDIS]};
    assign trans_tbl = `PFP_TRANS_TABLE;
    assign trans_ok = trans_tbl[{scen_cur, scen_new}];

    // reserved bit keeps its loaded value, software cannot change it
    assign w_spec = (wbyte & ~`PFP_RNV_MASK) | (prot_r & `PFP_RNV_MASK);

    // sizes only move while the matching range is currently disabled
    assign w_norm = {
        wbyte[`PFP_BIT_OPEN],
        prot_r[`PFP_BIT_RNV],
        wbyte[`PFP_BIT_HDIS],
        prot_r[`PFP_BIT_HDIS] ? wbyte[`PFP_HS_HI:`PFP_HS_LO] : prot_r[`PFP_HS_HI:`PFP_HS_LO],
        wbyte[`PFP_BIT_LDIS],
        prot_r[`PFP_BIT_LDIS] ? wbyte[`PFP_LS_HI:`PFP_LS_LO] : prot_r[`PFP_LS_HI:`PFP_LS_LO]
    };

    // ==========================================================
    // command screening
    logic range_refuse, cmd_blocked, cmd_hit_prot, cmd_ok;

    pfp_range_check u_check (
        .prot(prot_r),
        .addr(cmd_addr),
        .kind(cmd_kind),
        .refuse(range_refuse)
    );

    // no launch before the setting is loaded or while a violation stands
    assign cmd_blocked = viol_r | (load_r != PFP_LOAD_DONE);
    assign cmd_hit_prot = cmd_valid & ~cmd_blocked & range_refuse;
    assign cmd_ok = cmd_valid & ~cmd_blocked & ~range_refuse;

    // ==========================================================
    // next-state logic
    always_comb begin
        load_nxt = load_r;
        prot_nxt = prot_r;
        case (load_r)
            PFP_LOAD_WAIT: begin
                if (nv_valid) begin
                    load_nxt = PFP_LOAD_DONE;
                    // a faulty read leaves the array fully shielded
                    prot_nxt = nv_dbl_fault ? `PFP_PROT_FAULT : nv_data;
                end
            end
            PFP_LOAD_DONE: begin
                if (wr_prot) begin
                    if (mode_r) begin
                        prot_nxt = w_spec;
                    end else if (trans_ok) begin
                        prot_nxt = w_norm;
                    end
                end
            end
            default: begin
                load_nxt = PFP_LOAD_WAIT;
            end
        endcase
    end

    // violation flag: commands are blocked while it stands, so none can set it again in the clearing cycle
    assign viol_nxt = cmd_hit_prot | (viol_r & ~(wr_status & wbyte[`PFP_BIT_VIOL]));

    // ==========================================================
    // state registers; reset value shields everything until loaded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_r <= PFP_LOAD_WAIT;
            prot_r <= `PFP_PROT_RESET;
            viol_r <= 1'b0;
        end else begin
            load_r <= load_nxt;
            prot_r <= prot_nxt;
            viol_r <= viol_nxt;
        end
    end

    // one-cycle verdict pulses and the load request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            accept_r <= 1'b0;
            refuse_r <= 1'b0;
            nv_addr_r <= `PFP_NV_ADDR;
            nv_req_r <= 1'b1;
        end else begin
            accept_r <= cmd_ok;
            refuse_r <= cmd_valid & ~cmd_ok;
            nv_addr_r <= `PFP_NV_ADDR;
            nv_req_r <= load_nxt == PFP_LOAD_WAIT; // same timing as the load state
        end
    end

    // ==========================================================
    // outputs, all from flops
    assign nv_read_req = nv_req_r;
    assign nv_read_addr = nv_addr_r;
    assign cmd_accept = accept_r;
    assign cmd_refuse = refuse_r;
    assign prot_value = prot_r;
    assign protection_violation_flag = viol_r;
endmodule
`default_nettype wire

// ==== hw/pfp_pkg.sv ====
// types shared by the program flash protection controller
`default_nettype none
package pfp_pkg;
    // kind of array-modifying command offered for checking
    typedef enum logic [1:0] {
        PFP_CMD_PROGRAM,
        PFP_CMD_SECTOR_ERASE,
        PFP_CMD_BLOCK_ERASE,
        PFP_CMD_OTHER
    } pfp_cmd_e;

    // reset-time load of the protection byte
    typedef enum logic {
        PFP_LOAD_WAIT,
        PFP_LOAD_DONE
    } pfp_load_e;

    typedef logic [2:0] pfp_scen_t;
endpackage
`default_nettype wire

// ==== hw/pfp_range_check.sv ====
// decides whether a command address falls in protected program flash
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
module pfp_range_check (
    // active protection setting
    input wire logic [7:0] prot,
    // command under test
    input wire logic [`PFP_GADDR_W-1:0] addr,
    input wire pfp_pkg::pfp_cmd_e kind,
    // verdict
    output logic refuse
);
    import pfp_pkg::*;
    logic [`PFP_GADDR_W-1:0] hi_start, lo_end;
    logic in_array, in_hi, in_lo, in_ranges, addr_prot, any_prot, modifies;

    // range bounds from the size fields
    assign hi_start = `PFP_HI_START_MIN << prot[`PFP_HS_HI:`PFP_HS_LO];
    assign lo_end = `PFP_ARRAY_BASE + (`PFP_LO_SIZE_MIN << prot[`PFP_LS_HI:`PFP_LS_LO]);
    assign in_array = addr >= `PFP_ARRAY_BASE;
    assign in_hi = ~prot[`PFP_BIT_HDIS] & (addr >= hi_start);
    assign in_lo = ~prot[`PFP_BIT_LDIS] & in_array & (addr < lo_end);
    assign in_ranges = in_hi | in_lo;

    // polarity: enabled ranges shielded, or everything else shielded
    assign addr_prot = in_array & (prot[`PFP_BIT_OPEN] ? in_ranges : ~in_ranges);
    // ranges never cover the whole array, so clear polarity always shields some sector
    assign any_prot = prot[`PFP_BIT_OPEN] ? ~(prot[`PFP_BIT_HDIS] & prot[`PFP_BIT_LDIS]) : 1'b1;
    assign modifies = (kind == PFP_CMD_PROGRAM) | (kind == PFP_CMD_SECTOR_ERASE);

    // block erase is refused when any sector of the block is shielded
    assign refuse = (kind == PFP_CMD_BLOCK_ERASE) ? any_prot : (modifies & addr_prot);
endmodule
`default_nettype wire

// ==== hw/pfp_reg_if.sv ====
// register access carrier between the bus slave and the register file
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
interface pfp_reg_if;
    logic wr_en;
    logic [`PFP_ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_hit;
    logic [`PFP_ADDR_W-1:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_hit;

    modport slave (
        output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        input wr_hit, rd_data, rd_hit
    );
    modport regs (
        input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
        output wr_hit, rd_data, rd_hit
    );
endinterface
`default_nettype wire

// ==== verif/pfp_ctrl_monitor.sv ====
// concurrent checks on the protection controller ports
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
module pfp_ctrl_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write data channel
    input wire logic [31:0] s_wdata,
    input wire logic s_wvalid,
    input wire logic s_wready,
    // nonvolatile load
    input wire logic nv_read_req,
    input wire logic [`PFP_GADDR_W-1:0] nv_read_addr,
    input wire logic nv_valid,
    input wire logic [7:0] nv_data,
    input wire logic nv_dbl_fault,
    // command screening and state
    input wire logic cmd_valid,
    input wire logic cmd_accept,
    input wire logic cmd_refuse,
    input wire logic [7:0] prot_value,
    input wire logic protection_violation_flag
);
    // ==========================================================
    // one clock domain, so clock and reset are stated once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // command port: one answer for each offered command
    chk_cmd_answer: assert property (cmd_valid |=> cmd_accept != cmd_refuse)
        else $error("command not answered exactly once");
    chk_no_stray: assert property ((cmd_accept || cmd_refuse) |-> $past(cmd_valid))
        else $error("answer without a command");
    chk_flag_blocks: assert property (protection_violation_flag && cmd_valid |=> cmd_refuse)
        else $error("command launched while violation flag set");
    chk_load_gate: assert property (nv_read_req && cmd_valid |=> cmd_refuse)
        else $error("command accepted before protection load");
    chk_flag_cause: assert property ($rose(protection_violation_flag) |-> cmd_refuse && $past(cmd_valid))
        else $error("violation flag set without refused command");
    // flag only drops two edges after a one written to its bit
    chk_flag_clear: assert property ($fell(protection_violation_flag) |-> $past(s_wvalid && s_wready && s_wdata[4], 2))
        else $error("violation flag cleared without write of one");

    // ==========================================================
    // protection register: changes only by load or bus write
    chk_prot_cause: assert property ($changed(prot_value) |-> $past(s_wvalid && s_wready, 2) || $past(nv_valid))
        else $error("protection value changed without cause");
    chk_fault_full: assert property (nv_valid && nv_dbl_fault |=> prot_value == 8'h7f)
        else $error("faulty load did not give full protection");
    chk_nv_load: assert property (nv_valid && !nv_dbl_fault |=> prot_value == $past(nv_data))
        else $error("protection byte not loaded");
    chk_nv_addr: assert property (nv_read_req |-> nv_read_addr == 24'hfffe0c)
        else $error("wrong protection byte address");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// self-checking bench for the program flash protection controller
`timescale 1ns/1ps
`default_nettype none
`include "pfp_cfg.svh"
module tb;
    import pfp_pkg::*;
    // ==========================================================
    // design ports
    logic aclk = 1'h0, aresetn = 1'h0, special_mode = 1'h0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00, nv_data = 8'h00, prot_value;
    logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'h0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic nv_valid = 1'h0, nv_dbl_fault = 1'h0, cmd_valid = 1'h0, nv_read_req;
    logic cmd_accept, cmd_refuse, protection_violation_flag;
    logic [23:0] cmd_addr = 24'h0, nv_read_addr;
    pfp_cmd_e cmd_kind = PFP_CMD_OTHER;
    // ==========================================================
    // model state and bookkeeping
    localparam logic [7:0] TRN [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
    int failures = 0, check_count = 0, cyc = 0;
    logic [7:0] pm = 8'h7f;
    logic fm = 1'h0, loaded = 1'h0;
    logic [1:0] r;
    logic [31:0] d;

    pfp_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .special_mode(special_mode),
        .nv_read_req(nv_read_req), .nv_read_addr(nv_read_addr), .nv_valid(nv_valid),
        .nv_data(nv_data), .nv_dbl_fault(nv_dbl_fault), .cmd_valid(cmd_valid),
        .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_accept(cmd_accept),
        .cmd_refuse(cmd_refuse), .prot_value(prot_value),
        .protection_violation_flag(protection_violation_flag));

    // 10 mhz clock and hang guard
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // bus master: payload held until its own ready, answer taken at valid
    task automatic axw(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] st);
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= dt;
        s_wstrb <= st;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        s_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_awready && s_awvalid) s_awvalid <= 1'h0;
            if (s_wready && s_wvalid) s_wvalid <= 1'h0;
        end while (!s_bvalid);
        r = s_bresp;
        s_bready <= 1'h0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        s_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_arready && s_arvalid) s_arvalid <= 1'h0;
        end while (!s_rvalid);
        r = s_rresp;
        d = s_rdata;
        s_rready <= 1'h0;
    endtask

    // ==========================================================
    // reference model of ranges and write restrictions
    function automatic logic hit(logic [7:0] p, logic [23:0] a, logic [1:0] k);
        logic [24:0] hs, ls;
        logic hi, lo;
        hs = 25'h800 << p[4:3];
        ls = 25'h400 << p[1:0];
        hi = !p[5] && {1'h0, a} >= 25'h1000000 - hs;
        lo = !p[2] && a >= 24'hff8000 && {1'h0, a} < 25'hff8000 + ls;
        if (k == 2'h3 || a < 24'hff8000) return 1'h0;
        if (k == 2'h2) return !p[7] || !p[5] || !p[2];
        return p[7] ? (hi || lo) : !(hi || lo);
    endfunction

    function automatic logic [7:0] wmodel(logic [7:0] p, logic [7:0] b, logic sp);
        logic [7:0] n;
        n = {b[7], p[6], b[5:0]};
        if (sp) return n;
        if (!p[5]) n[4:3] = p[4:3];
        if (!p[2]) n[1:0] = p[1:0];
        return TRN[{p[7], p[5], p[2]}][{b[7], b[5], b[2]}] ? n : p;
    endfunction

    // addresses on both sides of the active range edges
    function automatic logic [23:0] pick();
        logic [23:0] hs, ls;
        hs = 24'h000800 << pm[4:3];
        ls = 24'h000400 << pm[1:0];
        case ($urandom % 6)
            0: return 24'hff8000 + ls - 24'h1;
            1: return 24'hff8000 + ls;
            2: return 24'h000000 - hs;
            3: return 24'hffffff - hs;
            4: return 24'hff8000 | 24'($urandom % 32'h8000);
            default: return 24'($urandom % 32'hff8000);
        endcase
    endfunction

    task automatic cmd(input logic [1:0] k, input logic [23:0] a);
        logic er;
        if (k == 2'h2) a[23:15] = 9'h1ff;
        er = !loaded || fm || hit(pm, a, k);
        @(posedge aclk);
        cmd_valid <= 1'h1;
        cmd_kind <= pfp_cmd_e'(k);
        cmd_addr <= a;
        @(posedge aclk);
        cmd_valid <= 1'h0;
        #1;
        if (loaded && er) fm = 1'h1;
        check("cmd_refuse", cmd_refuse, er);
        check("cmd_accept", cmd_accept, !er);
        check("viol_flag", protection_violation_flag, fm);
    endtask

    task automatic nv(input logic f, input logic [7:0] v);
        @(posedge aclk);
        nv_valid <= 1'h1;
        nv_data <= v;
        nv_dbl_fault <= f;
        @(posedge aclk);
        nv_valid <= 1'h0;
        #1;
        check("prot_load", prot_value, f ? 8'h7f : v);
        check("nv_req", nv_read_req, 1'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        d = $urandom(86);
        repeat (10) @(posedge aclk);
        check("prot_rst", prot_value, 8'h7f);
        aresetn <= 1'h1;
        cmd(2'h0, 24'hff9000);
        nv(1'h1, 8'hbc);
        $display("test fault_load done");
        aresetn <= 1'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        nv(1'h0, 8'hff); // reserved bit left erased
        loaded = 1'h1;
        pm = 8'hff;
        axw(8'h0c, 32'h0, 4'hf);
        check("bad_wr", r, 2'h2);
        axr(8'h0c);
        check("bad_rd", {r, d[29:0]}, 32'h80000000);
        axw(8'h08, 32'h0, 4'he);
        axr(8'h08);
        check("no_strb", d, {24'h0, pm});
        $display("test bus_map done");
        for (int i = 0; i < 40; i++) begin
            special_mode <= ($urandom % 3) == 0;
            repeat (3) @(posedge aclk);
            d = $urandom;
            axw(8'h08, d, 4'h1);
            check("wr_resp", r, 2'h0);
            pm = wmodel(pm, d[7:0], special_mode);
            axr(8'h08);
            check("prot_rd", d, {24'h0, pm});
            for (int j = 0; j < 4; j++) cmd(2'($urandom % 4), pick());
            if (fm) begin
                axw(8'h04, 32'h0, 4'h1);
                check("w0_flag", protection_violation_flag, 1'h1);
                axw(8'h04, 32'h10, 4'h1);
                fm = 1'h0;
                axr(8'h04);
                check("status", d, 32'h1);
            end
        end
        $display("test random_ops done");
        results();
    end
endmodule

bind pfp_ctrl pfp_ctrl_monitor mon (.aclk(aclk), .aresetn(aresetn), .s_wdata(s_wdata),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .nv_read_req(nv_read_req),
    .nv_read_addr(nv_read_addr), .nv_valid(nv_valid), .nv_data(nv_data),
    .nv_dbl_fault(nv_dbl_fault), .cmd_valid(cmd_valid), .cmd_accept(cmd_accept),
    .cmd_refuse(cmd_refuse), .prot_value(prot_value),
    .protection_violation_flag(protection_violation_flag));
`default_nettype wire
